/* adc_ctrl_pkg.sv */
/*
  Package for the sampling converter control block: code width, timing
  figures and the cycle counts derived from them at the system clock rate.
  Assumes a single 100 MHz clock; every time is converted by expression.
*/
package adc_ctrl_pkg;

  // ==========================================================================
  // Code format.
  localparam int unsigned CODE_W       = 12;
  localparam int unsigned CODE_STEPS   = 4096;
  localparam logic [11:0] CODE_RST     = 12'h000;
  localparam logic [11:0] CODE_ZERO    = 12'h000;
  localparam logic [11:0] CODE_ONE     = 12'h001;
  localparam logic [11:0] CODE_TOP_M1  = 12'hffe;
  localparam logic [11:0] CODE_TOP     = 12'hfff;

  // ==========================================================================
  // Timing, as printed, then in clock cycles.
  localparam int unsigned CLK_PERIOD_PS  = 10000;
  localparam int unsigned CONV_MAX_PS    = 750000;
  localparam int unsigned CONV_TYP_PS    = 700000;
  localparam int unsigned ACQ_MAX_PS     = 150000;
  localparam int unsigned THRU_PS        = 800000;
  localparam int unsigned NAP_WAKE_PS    = 200000;
  // Deep wake-up is held in microseconds: in picoseconds it would not fit.
  localparam int unsigned REF_WAKE_US    = 10000;
  // Typical conversion fits under the maximum; longest times round down.
  localparam int unsigned CONV_CYC  = CONV_TYP_PS / CLK_PERIOD_PS;
  localparam int unsigned ACQ_CYC   = ACQ_MAX_PS / CLK_PERIOD_PS;
  localparam int unsigned THRU_CYC  = THRU_PS / CLK_PERIOD_PS;
  localparam int unsigned NAP_CYC   =
    (NAP_WAKE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SLEEP_CYC =
    REF_WAKE_US * (1000000 / CLK_PERIOD_PS);
  localparam int unsigned CNT_W     = 20;

  // ==========================================================================
  // Power and conversion states.
  typedef enum logic [2:0] {
    ST_ACTIVE, ST_CONVERT, ST_ACQUIRE, ST_NAP, ST_SLEEP, ST_WAKE
  } adc_state_e;

endpackage : adc_ctrl_pkg

/* sar_if.sv */
/*
  Interface between the sequencer and the successive-approximation core.
  Assumes both ends run on the same clock.
*/
interface sar_if;
  logic        start;
  logic [11:0] sample;
  logic        done;
  logic [11:0] result;

  modport ctrl (output start, output sample, input done, input result);
  modport core (input start, input sample, output done, output result);
endinterface : sar_if

/* sar_core.sv */
/*
  Successive-approximation register: one bit decided per step, MSB first,
  against a held digital sample that stands in for the comparator.
  Assumes the sample is held steady from start to done.
*/
module sar_core
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned STEP_CYC = CONV_CYC / CODE_W
) (
  // Clock and reset.
  input  wire logic i_clock,
  input  wire logic i_nrst,
  // Sequencer side.
  sar_if.core       sar
);

  logic [11:0] trial_ff, bit_ff;
  logic [7:0]  step_ff;
  logic        busy_ff, done_ff;
  logic [11:0] result_ff;
  wire  [11:0] guess    = trial_ff | bit_ff;
  wire         keep_bit = (sar.sample >= guess);
  wire         step_end = (step_ff == 8'(STEP_CYC - 1));

  // ==========================================================================
  // Binary search, so a held sample of code n always yields n.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      trial_ff  <= CODE_RST;
      bit_ff    <= CODE_RST;
      step_ff   <= 8'h00;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      result_ff <= CODE_RST;
    end else begin
      done_ff <= 1'b0;
      if (sar.start && !busy_ff) begin
        trial_ff <= CODE_RST;
        bit_ff   <= 12'h800;
        step_ff  <= 8'h00;
        busy_ff  <= 1'b1;
      end else if (busy_ff) begin
        step_ff <= step_end ? 8'h00 : step_ff + 8'h01;
        if (step_end) begin
          if (keep_bit) trial_ff <= guess;
          bit_ff <= bit_ff >> 1;
          if (bit_ff == 12'h001) begin
            busy_ff   <= 1'b0;
            done_ff   <= 1'b1;
            result_ff <= keep_bit ? guess : trial_ff;
          end
        end
      end
    end
  end

  assign sar.done   = done_ff;
  assign sar.result = result_ff;

endmodule : sar_core

/* adc_ctrl.sv */
/*
  Conversion and power-down control for a 12-bit sampling converter with a
  memory-mapped read port and a separate conversion-start pin.
  Assumes host pins are asynchronous, so each passes two flip-flops, and the
  analog sample arrives already quantised to the nearest whole step.
  Power-down requests are honoured only between conversions.
*/
// Overview of operation
// - Result is 12-bit straight binary, 4096 steps.
// - Code transitions sit at half-step points.
// - Half-step input toggles codes zero and one.
// - Full scale minus 1.5 toggles top codes.
// - Self-timed conversion, at most 0.75 us.
// - Acquisition done within 150 ns after conversion.
// - Full cycle every 800 ns, 1.25 Msps; here conversion plus acquisition take 72 cycles, 720 ns.
// - Host uses chip select, read, conversion-start.
// - Light power-down keeps only logic, reference.
// - Light wake-up takes 200 ns before conversions.
// - Deep power-down; wait for reference resettling.
// - Low shutdown powers down; select picks depth.
// - Start falling while chip selected begins conversion.
// - Starts ignored while a conversion runs.
// - Busy low for the whole conversion.
module adc_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned SLEEP_WAKE_CYC = SLEEP_CYC
) (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // Host bus pins.
  input  wire logic        i_chip_select_n,
  input  wire logic        i_read_n,
  input  wire logic        i_conversion_start_n,
  input  wire logic        i_power_down_n,
  input  wire logic        i_light_deep_select,
  // Quantised sample from the front end, rounded to the nearest step.
  input  wire logic [11:0] i_sample_code,
  // Data port: output, output enable.
  output logic      [11:0] o_data,
  output logic             o_data_oe,
  // Status.
  output logic             o_busy_n,
  output logic             o_ready,
  output logic             o_bias_on,
  output logic             o_analog_on
);

  sar_if sar ();

  // ==========================================================================
  // Synchronisers: stage one is read only by stage two.
  // Every host pin is asynchronous to this clock, so each costs two cycles
  // of latency before the sequencer sees it; host timing must allow it.
  logic [4:0] meta_ff, sync_ff;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_ff <= 5'h1f;
      sync_ff <= 5'h1f;
    end else begin
      meta_ff <= {i_chip_select_n, i_read_n, i_conversion_start_n,
                  i_power_down_n, i_light_deep_select};
      sync_ff <= meta_ff;
    end
  end

  // Named taps of the second stage; nothing else reads the first.
  wire cs_n_s   = sync_ff[4];
  wire rd_n_s   = sync_ff[3];
  wire conv_n_s = sync_ff[2];
  wire pd_n_s   = sync_ff[1];
  wire light_s  = sync_ff[0];

  // Start is a falling edge; a low held across power-up reads as one when reset lifts.
  // Chip select passes the same two-stage delay, so both pins are seen on
  // one edge when the host moves them together.
  logic conv_n_d_ff;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) conv_n_d_ff <= 1'b1;
    else         conv_n_d_ff <= conv_n_s;
  end
  wire start_req = conv_n_d_ff && !conv_n_s && !cs_n_s;

  // ==========================================================================
  // Sequencer state and its counter. One down-counter serves every timed
  // interval: the acquisition tail after a conversion, the light wake-up
  // and the deep wake-up. The deep wake-up is by far the longest, so it
  // sets the counter width; a shorter value only shortens the wait.
  adc_state_e  state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [11:0] sample_ff, nxt_sample;
  logic [11:0] result_ff;

  wire cnt_zero = (cnt_ff == '0);
  wire pd_req   = !pd_n_s;

  // Next-state logic: power-down wins over everything but a running
  // conversion, which is let finish so the output never holds half a code.
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_zero ? cnt_ff : cnt_ff - 1'b1;
    nxt_sample = sample_ff;
    unique case (state_ff)
      // Idle and ready: shutdown is looked at first, then a start edge.
      ST_ACTIVE: begin
        if (pd_req) begin
          nxt_state = light_s ? ST_NAP : ST_SLEEP;
        end else if (start_req) begin
          nxt_state  = ST_CONVERT;
          nxt_sample = i_sample_code;
          nxt_cnt    = CNT_W'(CONV_CYC);
        end
      end
      // Converting: the core owns the held sample until done.
      ST_CONVERT: begin
        // Further start edges are simply not looked at here.
        if (sar.done) begin
          nxt_state = ST_ACQUIRE;
          nxt_cnt   = CNT_W'(THRU_CYC - CONV_CYC);
        end
      end
      // Acquisition tail lasts THRU_CYC - CONV_CYC + 1 cycles; after the 61-cycle conversion the cycle ends short of the throughput period.
      ST_ACQUIRE: begin
        if (pd_req) nxt_state = light_s ? ST_NAP : ST_SLEEP;
        else if (cnt_zero) nxt_state = ST_ACTIVE;
      end
      // Light power-down: wake on release, deepen if the select drops.
      ST_NAP: begin
        if (!pd_req) begin
          nxt_state = ST_WAKE;
          nxt_cnt   = CNT_W'(NAP_CYC);
        end else if (!light_s) begin
          nxt_state = ST_SLEEP;
        end
      end
      // Deep power-down: only a release of shutdown leaves it.
      ST_SLEEP: begin
        if (!pd_req) begin
          nxt_state = ST_WAKE;
          nxt_cnt   = CNT_W'(SLEEP_WAKE_CYC);
        end
      end
      // Wake-up count; a new shutdown request cuts it short.
      ST_WAKE: begin
        if (pd_req) nxt_state = light_s ? ST_NAP : ST_SLEEP;
        else if (cnt_zero) nxt_state = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff  <= ST_ACTIVE;
      cnt_ff    <= '0;
      sample_ff <= CODE_RST;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      sample_ff <= nxt_sample;
    end
  end

  // ==========================================================================
  // Conversion core; its step time is set so twelve steps fit the budget.
  // The core is started once per accepted edge and reports done for one
  // cycle; the sequencer never starts it again before that pulse.
  assign sar.start  = (state_ff == ST_ACTIVE) && (nxt_state == ST_CONVERT);
  assign sar.sample = nxt_sample;

  sar_core #(
    .STEP_CYC (CONV_CYC / CODE_W)
  ) u_sar (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .sar     (sar)
  );

  // Result register loads the cycle done arrives, on the same edge busy returns high.
  // It is the code the read port shows until the next conversion ends.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst)       result_ff <= CODE_RST;
    else if (sar.done) result_ff <= sar.result;
  end

  // ==========================================================================
  // Outputs. Previous result stays on the pins during a conversion; the
  // host is expected to wait on busy rather than sample mid-conversion.
  // Busy is registered from the next state, so it falls with the start.
  logic busy_n_ff, oe_ff;
  logic [11:0] data_ff;
  wire  converting = (nxt_state == ST_CONVERT);
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_n_ff <= 1'b1;
      oe_ff     <= 1'b0;
      data_ff   <= CODE_RST;
    end else begin
      busy_n_ff <= !converting;
      oe_ff     <= !cs_n_s && !rd_n_s;
      data_ff   <= sar.done ? sar.result : result_ff;
    end
  end

  assign o_busy_n    = busy_n_ff;
  assign o_data      = data_ff;
  assign o_data_oe   = oe_ff;
  // ==========================================================================
  // Power status decode. Only deep power-down cuts bias; light power-down
  // keeps logic and reference alive so that its wake-up stays short.
  wire in_deep  = (state_ff == ST_SLEEP);
  wire in_light = (state_ff == ST_NAP);
  wire is_idle  = (state_ff == ST_ACTIVE);

  assign o_ready     = is_idle;
  assign o_bias_on   = !in_deep;
  assign o_analog_on = !in_deep && !in_light;

endmodule : adc_ctrl

/* adc_ctrl_monitor.sv */
/* Port checker for adc_ctrl.
   Assumes one clock and the bind at the foot of this file. */
module adc_ctrl_monitor #(
  parameter int unsigned SLEEP_WAKE_CYC = 1000000
) (
  // Clock, reset and host pins.
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        i_chip_select_n,
  input wire logic        i_read_n,
  input wire logic        i_power_down_n,
  input wire logic        i_light_deep_select,
  // Converter outputs.
  input wire logic [11:0] o_data,
  input wire logic        o_data_oe,
  input wire logic        o_busy_n,
  input wire logic        o_ready,
  input wire logic        o_bias_on,
  input wire logic        o_analog_on
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Assertions share the one clock and the reset.
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  // Cycles since bias returned; it saturates so a long idle never wraps.
  int unsigned wake_cnt_ff;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wake_cnt_ff <= SLEEP_WAKE_CYC;
    end else if (!o_bias_on) begin
      wake_cnt_ff <= 0;
    end else if (wake_cnt_ff < SLEEP_WAKE_CYC) begin
      wake_cnt_ff <= wake_cnt_ff + 1;
    end
  end

  a_busy_min: assert property (
    $fell(o_busy_n) |-> !o_busy_n [*8])
    else $error("busy pulse too short");
  a_busy_max: assert property (
    $fell(o_busy_n) |-> ##[1:75] o_busy_n)
    else $error("conversion overran");
  a_data_at_busy: assert property (
    $changed(o_data) |-> $rose(o_busy_n))
    else $error("data moved off busy rise");
  a_acq_tail: assert property (
    $rose(o_busy_n) && i_power_down_n |-> ##[1:15] o_ready)
    else $error("acquire tail too long");
  a_no_restart: assert property (!o_busy_n |-> !o_ready)
    else $error("ready during conversion");
  a_oe_on: assert property (
    (!i_chip_select_n && !i_read_n) [*5] |-> o_data_oe)
    else $error("data not driven on read");
  a_light_bias: assert property (
    (!i_power_down_n && i_light_deep_select) [*8]
    |-> o_bias_on && !o_analog_on)
    else $error("light power-down wrong");
  a_deep_bias: assert property (!o_bias_on |-> !o_analog_on)
    else $error("bias off with analog on");
  a_light_wake: assert property (
    $rose(i_power_down_n) |-> !o_ready [*8])
    else $error("ready too soon after wake");
  a_deep_wake: assert property (
    $rose(o_ready) |-> wake_cnt_ff >= SLEEP_WAKE_CYC)
    else $error("ready too soon after deep wake");
  // The main scenarios are reached.
  c_result: cover property ($rose(o_busy_n));
  c_deep: cover property (!o_bias_on);
  c_read: cover property (o_data_oe);
  c_light: cover property (o_bias_on && !o_analog_on);
endmodule : adc_ctrl_monitor

bind adc_ctrl adc_ctrl_monitor #(.SLEEP_WAKE_CYC(SLEEP_WAKE_CYC)) mon (
  .i_clock, .i_nrst, .i_chip_select_n, .i_read_n, .i_power_down_n,
  .i_light_deep_select, .o_data, .o_data_oe, .o_busy_n, .o_ready,
  .o_bias_on, .o_analog_on);

/* host_bus_model.sv */
/* Host bus model that turns bench requests into converter pins.
   Assumes requests change just after a rising clock edge. */
module host_bus_model (
  // Clock and converter status.
  input  wire logic i_clock,
  input  wire logic i_busy_n,
  // Requests from the bench.
  input  wire logic i_start_req,
  input  wire logic i_read_req,
  input  wire logic i_pd_req,
  input  wire logic i_light,
  // Converter pins.
  output logic      o_cs_n    = 1'b1,
  output logic      o_rd_n    = 1'b1,
  output logic      o_start_n = 1'b1,
  output logic      o_pd_n    = 1'b1,
  output logic      o_sel     = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Pins follow requests by an edge; shutdown waits for a settled select.
  always @(posedge i_clock) begin
    o_sel     <= i_light;
    o_pd_n    <= !(i_pd_req && o_sel == i_light);
    o_cs_n    <= !(i_start_req || i_read_req);
    o_start_n <= !i_start_req;
    o_rd_n    <= !(i_read_req && i_busy_n); // Read strobe held off while busy
  end
endmodule : host_bus_model

/* adc_ctrl_tb.sv */
/* Testbench for adc_ctrl: codes, restart, read and both power-downs.
   Assumes the host model and the bound checker are compiled first. */
module adc_ctrl_tb
  import adc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Short deep wake keeps the run brief.
  localparam int unsigned WAKE = 50;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        req_start = 1'b0, req_read = 1'b0, req_pd = 1'b0;
  logic        light = 1'b1;
  logic [11:0] sample = 12'h000;
  logic        cs_n, rd_n, start_n, pd_n, sel;
  logic        oe, busy_n, ready, bias, analog;
  logic [11:0] data;
  int          err_count = 0;
  int          tests_run = 0;
  host_bus_model host (.i_clock(clk), .i_busy_n(busy_n),
    .i_start_req(req_start), .i_read_req(req_read), .i_pd_req(req_pd),
    .i_light(light), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_start_n(start_n),
    .o_pd_n(pd_n), .o_sel(sel));
  adc_ctrl #(.SLEEP_WAKE_CYC(WAKE)) dut (.i_clock(clk), .i_nrst(nrst),
    .i_chip_select_n(cs_n), .i_read_n(rd_n), .i_conversion_start_n(start_n),
    .i_power_down_n(pd_n), .i_light_deep_select(sel),
    .i_sample_code(sample), .o_data(data), .o_data_oe(oe),
    .o_busy_n(busy_n), .o_ready(ready), .o_bias_on(bias),
    .o_analog_on(analog));
  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // Bounded wait on busy or ready; a hang counts as a mismatch.
  task automatic wait_lvl(input bit rdy, input logic lvl, output int n);
    n = 0;
    while ((rdy ? ready : busy_n) !== lvl) begin
      @(posedge clk);
      n++;
      if (n > 400) begin
        err_count++;
        close_out();
      end
    end
  endtask : wait_lvl
  // One conversion; n is the busy-low length in cycles.
  task automatic convert(input logic [11:0] code, output int n);
    int m;
    sample    <= code;
    req_start <= 1'b1;
    repeat (3) @(posedge clk);
    req_start <= 1'b0;
    wait_lvl(1'b0, 1'b0, m);
    wait_lvl(1'b0, 1'b1, n);
  endtask : convert
  // End codes and a mid code come back whole, each inside its budget.
  task automatic test_codes;
    logic [11:0] codes [5] = '{12'h000, 12'h001, 12'hffe, 12'hfff, 12'ha5c};
    int n;
    foreach (codes[i]) begin
      convert(codes[i], n);
      check("result", data, codes[i]);
      check("conv time", 12'(n <= 75), 12'h001);
      wait_lvl(1'b1, 1'b1, n);
      check("acq time", 12'(n <= 15), 12'h001);
    end
    $display("codes test done");
  endtask : test_codes
  // A second start inside a conversion must not restart it.
  task automatic test_restart;
    int n;
    sample    <= 12'h3c7;
    req_start <= 1'b1;
    wait_lvl(1'b0, 1'b0, n);
    sample    <= 12'h5a1;
    req_start <= 1'b0;
    repeat (5) @(posedge clk);
    req_start <= 1'b1;
    repeat (5) @(posedge clk);
    req_start <= 1'b0;
    wait_lvl(1'b0, 1'b1, n);
    check("held result", data, 12'h3c7);
    repeat (30) @(posedge clk);
    check("no late start", {11'h0, busy_n}, 12'h001);
    $display("restart test done");
  endtask : test_restart
  // Read drives the port, release floats it again.
  task automatic test_read;
    req_read <= 1'b1;
    repeat (6) @(posedge clk);
    check("oe on", {11'h0, oe}, 12'h001);
    check("read data", data, 12'h3c7);
    req_read <= 1'b0;
    repeat (6) @(posedge clk);
    check("oe off", {11'h0, oe}, 12'h000);
    $display("read test done");
  endtask : test_read
  // Power down, see a start refused, then wake and convert again.
  task automatic test_power(input logic lite, input int wake);
    int n;
    // Shut down only once the acquire tail has ended and ready is back.
    wait_lvl(1'b1, 1'b1, n);
    light <= lite;
    @(posedge clk);
    req_pd <= 1'b1;
    repeat (10) @(posedge clk);
    check("analog on", {11'h0, analog}, 12'h000);
    check("bias on", {11'h0, bias}, {11'h0, lite});
    req_start <= 1'b1;
    repeat (5) @(posedge clk);
    check("start refused", {11'h0, busy_n}, 12'h001);
    req_start <= 1'b0;
    req_pd    <= 1'b0;
    wait_lvl(1'b1, 1'b1, n);
    check("wake time", 12'(n >= wake), 12'h001);
    convert(12'h7e5, n);
    check("after wake", data, 12'h7e5);
    $display("power test done");
  endtask : test_power
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end
  // Main sequence, ending in the one verdict.
  initial begin
    repeat (12) @(posedge clk);
    check("reset data", data, CODE_RST);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    test_codes();
    test_restart();
    test_read();
    test_power(1'b1, 20);
    test_power(1'b0, WAKE);
    close_out();
  end
endmodule : adc_ctrl_tb
